/* File: hw/actuator_position_object.sv */
// positioning-control object of a linear valve actuator
// Operation
// - switch reads 0 remote, 1 local; local ignores network positioning commands
// - target and forced commands act only while run permit is 1
// - target is setpoint, -50..10050 in 0.01 %, truncated to 0.1 %
// - any forced command overrides the target position input
// - feedback reports stem position, 0 % clockwise end, 100 % other end
// - settled flag is 1 inside deadband around setpoint, else 0
// - deadband 10..1000 default 50, applied in odd 0.1 % steps to 9.9 %
// - after stopping, no restart before hold-off time of 0..255 x 0.1 s
// - forced retract goes to retract target, extend to extend target; write-only
// - retract target 0..10050 default 10000, extend target -50..10000 default 0
// - retract flag on while position above retract threshold, default 9800
// - extend flag on while position below extend threshold, default 200
// - summary error is 1 when stall, range or storage fault is set
// - stall fault after retry limit of stalls cuts motor; clear input resets
// - target write outside -50..10050 sets range fault
// - storage error sets storage fault and disables operation
`timescale 1ns/100ps
module actuator_position_object #(
   parameter int HOLDOFF_TICK_CYCLES = actuator_pkg::HOLDOFF_UNIT_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic local_switch,
   input wire logic motor_stalled,
   input wire logic clear_stall,
   input wire logic memory_error,
   input wire logic [15:0] stem_position,
   input wire logic [7:0] retry_limit,
   input wire logic attr_class,
   input wire logic [7:0] attr_id,
   input wire logic attr_rd,
   input wire logic attr_wr,
   input wire logic [15:0] attr_wdata,
   output logic attr_ack,
   output logic attr_err,
   output logic [15:0] attr_rdata,
   output logic motor_retract,
   output logic motor_extend,
   output logic [15:0] stem_setpoint,
   output logic position_settled,
   output logic retract_limit_flag,
   output logic extend_limit_flag,
   output logic fault_summary
);
   logic rst_meta;
   logic rst_n;
   logic local_mode;
   logic stalled;
   logic clearing;
   logic run_permit;
   logic [15:0] target_position_input;
   logic [15:0] settle_window;
   logic [7:0] restart_holdoff_time;
   logic force_retract_cmd;
   logic force_extend_cmd;
   logic [15:0] retract_force_target;
   logic [15:0] extend_force_target;
   logic [15:0] retract_flag_threshold;
   logic [15:0] extend_flag_threshold;
   logic [15:0] position_feedback;
   logic stall_fault;
   logic range_fault;
   logic storage_fault;
   logic [7:0] attempts;
   logic [actuator_pkg::HOLDOFF_CNT_W-1:0] unit_cnt;
   logic [7:0] units_left;
   actuator_pkg::motion_t state;

   // release reset through two flops
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   pin_sync u_local (.clk_sys(clk_sys), .rst_n(rst_n), .pin(local_switch), .level(local_mode));
   pin_sync u_stall (.clk_sys(clk_sys), .rst_n(rst_n), .pin(motor_stalled), .level(stalled));
   pin_sync u_clear (.clk_sys(clk_sys), .rst_n(rst_n), .pin(clear_stall), .level(clearing));

   // attribute decode
   logic wr_inst;
   logic net_cmd;
   logic signed [15:0] wval;
   logic target_ok;
   logic signed [15:0] truncated;
   assign wr_inst = attr_wr && !attr_class;
   assign wval = $signed(attr_wdata);
   assign net_cmd = (attr_id == actuator_pkg::ID_RUN_PERMIT) ||
                    (attr_id == actuator_pkg::ID_TARGET) ||
                    (attr_id == actuator_pkg::ID_FORCE_RETRACT) ||
                    (attr_id == actuator_pkg::ID_FORCE_EXTEND);
   assign target_ok = (wval >= actuator_pkg::POS_MIN) && (wval <= actuator_pkg::POS_MAX);
   // truncation toward zero drops the hundredths digit
   assign truncated = wval - (wval % actuator_pkg::TARGET_STEP);

   // range check for each writable attribute but the target, whose bad values set range fault instead; bad values are refused
   logic wr_legal;
   always_comb begin
      wr_legal = 1'b0;
      case (attr_id)
         actuator_pkg::ID_RUN_PERMIT,
         actuator_pkg::ID_FORCE_RETRACT,
         actuator_pkg::ID_FORCE_EXTEND:
            wr_legal = !local_mode && (attr_wdata[15:1] == 15'h0000);
         actuator_pkg::ID_TARGET: wr_legal = !local_mode;
         actuator_pkg::ID_SETTLE_WINDOW:
            wr_legal = (attr_wdata >= actuator_pkg::WINDOW_MIN) &&
                       (attr_wdata <= actuator_pkg::WINDOW_MAX);
         actuator_pkg::ID_HOLDOFF: wr_legal = (attr_wdata[15:8] == 8'h00);
         actuator_pkg::ID_RETRACT_TARGET,
         actuator_pkg::ID_RETRACT_THRESH:
            wr_legal = (wval >= actuator_pkg::POS_ZERO) &&
                       (wval <= actuator_pkg::POS_MAX);
         actuator_pkg::ID_EXTEND_TARGET,
         actuator_pkg::ID_EXTEND_THRESH:
            wr_legal = (wval >= actuator_pkg::POS_MIN) &&
                       (wval <= actuator_pkg::POS_FULL);
         default: wr_legal = 1'b0;
      endcase
   end

   // writable settings
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         run_permit <= 1'b0;
         target_position_input <= 16'h0000;
         settle_window <= actuator_pkg::RST_SETTLE_WINDOW;
         restart_holdoff_time <= actuator_pkg::RST_HOLDOFF;
         force_retract_cmd <= 1'b0;
         force_extend_cmd <= 1'b0;
         retract_force_target <= actuator_pkg::RST_RETRACT_TARGET;
         extend_force_target <= actuator_pkg::RST_EXTEND_TARGET;
         retract_flag_threshold <= actuator_pkg::RST_RETRACT_THRESH;
         extend_flag_threshold <= actuator_pkg::RST_EXTEND_THRESH;
      end else if (wr_inst && wr_legal) begin
         case (attr_id)
            actuator_pkg::ID_RUN_PERMIT: run_permit <= attr_wdata[0];
            actuator_pkg::ID_TARGET: begin
               if (target_ok) begin
                  target_position_input <= truncated;
               end
            end
            actuator_pkg::ID_SETTLE_WINDOW: settle_window <= attr_wdata;
            actuator_pkg::ID_HOLDOFF: restart_holdoff_time <= attr_wdata[7:0];
            actuator_pkg::ID_FORCE_RETRACT: force_retract_cmd <= attr_wdata[0];
            actuator_pkg::ID_FORCE_EXTEND: force_extend_cmd <= attr_wdata[0];
            actuator_pkg::ID_RETRACT_TARGET: retract_force_target <= attr_wdata;
            actuator_pkg::ID_EXTEND_TARGET: extend_force_target <= attr_wdata;
            actuator_pkg::ID_RETRACT_THRESH: retract_flag_threshold <= attr_wdata;
            actuator_pkg::ID_EXTEND_THRESH: extend_flag_threshold <= attr_wdata;
            default: run_permit <= run_permit;
         endcase
      end
   end

   // range fault follows the last accepted target write
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         range_fault <= 1'b0;
      end else if (wr_inst && wr_legal && attr_id == actuator_pkg::ID_TARGET) begin
         range_fault <= !target_ok;
      end
   end

   // storage fault is sticky until reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         storage_fault <= 1'b0;
      end else if (memory_error) begin
         storage_fault <= 1'b1;
      end
   end

   // setpoint selection; retract wins if both forced commands are on
   logic [15:0] next_setpoint;
   always_comb begin
      if (force_retract_cmd) begin
         next_setpoint = retract_force_target;
      end else if (force_extend_cmd) begin
         next_setpoint = extend_force_target;
      end else begin
         next_setpoint = target_position_input;
      end
   end

   // applied deadband in 0.1 % units: odd values 1..99
   logic [15:0] tenths;
   logic [15:0] db_tenths;
   logic [17:0] db_window;
   logic signed [16:0] err;
   logic [16:0] abs_err;
   logic settled_now;
   assign tenths = settle_window / actuator_pkg::WINDOW_STEP;
   always_comb begin
      if (tenths > actuator_pkg::WINDOW_TENTHS_MAX) begin
         db_tenths = actuator_pkg::WINDOW_TENTHS_MAX;
      end else if (!tenths[0]) begin
         db_tenths = tenths - 16'd1;
      end else begin
         db_tenths = tenths;
      end
   end
   // window is 10x tenths in 0.01 % units; compare against twice the error
   assign db_window = 18'({db_tenths, 3'b000}) + 18'({db_tenths, 1'b0});
   assign err = 17'($signed(stem_setpoint)) - 17'($signed(stem_position));
   assign abs_err = err[16] ? 17'(-err) : 17'(err);
   assign settled_now = {abs_err, 1'b0} <= db_window;

   // motion is only allowed from the network with the permit on and no stall or storage fault
   logic can_run;
   assign can_run = !local_mode && run_permit && !stall_fault && !storage_fault;

   // motion sequencer with restart hold-off
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= actuator_pkg::ST_READY;
         unit_cnt <= '0;
         units_left <= 8'h00;
      end else begin
         case (state)
            actuator_pkg::ST_READY: begin
               if (can_run && !settled_now && !stalled) begin
                  state <= actuator_pkg::ST_MOVE;
               end
            end
            actuator_pkg::ST_MOVE: begin
               if (!can_run || settled_now || stalled) begin
                  state <= actuator_pkg::ST_HOLD;
                  unit_cnt <= '0;
                  units_left <= restart_holdoff_time;
               end
            end
            actuator_pkg::ST_HOLD: begin
               if (units_left == 8'h00) begin
                  state <= actuator_pkg::ST_READY;
               end else if (unit_cnt ==
                            actuator_pkg::HOLDOFF_CNT_W'(HOLDOFF_TICK_CYCLES - 1)) begin
                  unit_cnt <= '0;
                  units_left <= units_left - 8'h01;
               end else begin
                  unit_cnt <= unit_cnt + 1'b1;
               end
            end
            default: state <= actuator_pkg::ST_READY;
         endcase
      end
   end

   // consecutive stall count; a stall during the clear does not latch the fault
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         attempts <= 8'h00;
         stall_fault <= 1'b0;
      end else if (clearing) begin
         attempts <= 8'h00;
         stall_fault <= 1'b0;
      end else if (state == actuator_pkg::ST_MOVE && stalled) begin
         attempts <= attempts + 8'h01;
         if (attempts + 8'h01 >= retry_limit) begin
            stall_fault <= 1'b1;
         end
      end else if (state == actuator_pkg::ST_MOVE && settled_now) begin
         attempts <= 8'h00;
      end
   end

   // motor drive and status flags
   logic moving;
   assign moving = (state == actuator_pkg::ST_MOVE) && can_run && !settled_now && !stalled;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         motor_retract <= 1'b0;
         motor_extend <= 1'b0;
      end else begin
         motor_retract <= moving && !err[16];
         motor_extend <= moving && err[16];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stem_setpoint <= 16'h0000;
         position_feedback <= 16'h0000;
         position_settled <= 1'b0;
         retract_limit_flag <= 1'b0;
         extend_limit_flag <= 1'b0;
         fault_summary <= 1'b0;
      end else begin
         stem_setpoint <= next_setpoint;
         position_feedback <= stem_position;
         position_settled <= settled_now;
         retract_limit_flag <= $signed(stem_position) > $signed(retract_flag_threshold);
         extend_limit_flag <= $signed(stem_position) < $signed(extend_flag_threshold);
         fault_summary <= stall_fault || range_fault || storage_fault;
      end
   end

   // attribute answer, one cycle after the request
   logic [15:0] next_rdata;
   logic next_err;
   always_comb begin
      next_rdata = 16'h0000;
      next_err = 1'b0;
      if (attr_class) begin
         next_err = attr_wr || (attr_id != actuator_pkg::ID_CLASS_VERSION);
         next_rdata = next_err ? 16'h0000 : actuator_pkg::CLASS_VERSION;
      end else if (attr_wr) begin
         next_err = !wr_legal;
      end else begin
         case (attr_id)
            actuator_pkg::ID_SOURCE_SWITCH: next_rdata = {15'h0000, local_mode};
            actuator_pkg::ID_RUN_PERMIT: next_rdata = {15'h0000, run_permit};
            actuator_pkg::ID_TARGET: next_rdata = target_position_input;
            actuator_pkg::ID_POSITION: next_rdata = position_feedback;
            actuator_pkg::ID_SETTLED: next_rdata = {15'h0000, position_settled};
            actuator_pkg::ID_SETTLE_WINDOW: next_rdata = settle_window;
            actuator_pkg::ID_HOLDOFF: next_rdata = {8'h00, restart_holdoff_time};
            actuator_pkg::ID_RETRACT_TARGET: next_rdata = retract_force_target;
            actuator_pkg::ID_EXTEND_TARGET: next_rdata = extend_force_target;
            actuator_pkg::ID_RETRACT_FLAG: next_rdata = {15'h0000, retract_limit_flag};
            actuator_pkg::ID_EXTEND_FLAG: next_rdata = {15'h0000, extend_limit_flag};
            actuator_pkg::ID_RETRACT_THRESH: next_rdata = retract_flag_threshold;
            actuator_pkg::ID_EXTEND_THRESH: next_rdata = extend_flag_threshold;
            actuator_pkg::ID_FAULT_SUMMARY: next_rdata = {15'h0000, fault_summary};
            default: next_err = 1'b1; // forced commands are write-only
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         attr_ack <= 1'b0;
         attr_err <= 1'b0;
         attr_rdata <= 16'h0000;
      end else begin
         attr_ack <= attr_rd || attr_wr;
         attr_err <= (attr_rd || attr_wr) && next_err;
         attr_rdata <= (attr_rd && !attr_wr) ? next_rdata : 16'h0000;
      end
   end

   AST_LOCAL_REFUSES: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_inst && local_mode && net_cmd) |=> attr_err && $stable(run_permit))
      else $error("network command taken in local mode");

   AST_NO_PERMIT_NO_MOTION: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !run_permit |=> !motor_retract && !motor_extend)
      else $error("motor driven without run permit");

   AST_TARGET_TRUNC: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(target_position_input) |->
      ($signed(target_position_input) % actuator_pkg::TARGET_STEP) == 16'sd0)
      else $error("target keeps hundredths digit");

   AST_FORCED_OVERRIDES: assert property (@(posedge clk_sys) disable iff (!rst_n)
      force_retract_cmd |=>
      stem_setpoint == $past(retract_force_target))
      else $error("forced retract target not applied");

   AST_SETTLED_MATCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
      settled_now |=> position_settled)
      else $error("settled flag lost inside deadband");

   AST_HOLDOFF_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == actuator_pkg::ST_HOLD && units_left != 8'h00) |=>
      state == actuator_pkg::ST_HOLD)
      else $error("restart before hold-off elapsed");

   AST_RETRACT_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ($signed(stem_position) > $signed(retract_flag_threshold)) ##1
      $stable(retract_flag_threshold) |-> retract_limit_flag)
      else $error("retract flag missing above threshold");

   AST_SUMMARY: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (stall_fault || range_fault || storage_fault) |=> fault_summary)
      else $error("summary error not raised");

   AST_STALL_CUTS_POWER: assert property (@(posedge clk_sys) disable iff (!rst_n)
      stall_fault |-> ##1 (!motor_retract && !motor_extend)[*2])
      else $error("motor powered after stall fault");

   AST_RANGE_FAULT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_inst && !local_mode && attr_id == actuator_pkg::ID_TARGET && !target_ok) |=>
      range_fault ##1 fault_summary)
      else $error("out of range target not flagged");
endmodule

/* File: hw/actuator_pkg.sv */
// constants shared by the actuator positioning object
package actuator_pkg;
   // attribute identifiers (class attribute space and instance attribute space)
   localparam logic [7:0] ID_CLASS_VERSION = 8'h01;
   localparam logic [7:0] ID_SOURCE_SWITCH = 8'h64;
   localparam logic [7:0] ID_RUN_PERMIT = 8'h65;
   localparam logic [7:0] ID_TARGET = 8'h66;
   localparam logic [7:0] ID_POSITION = 8'h67;
   localparam logic [7:0] ID_SETTLED = 8'h68;
   localparam logic [7:0] ID_SETTLE_WINDOW = 8'h69;
   localparam logic [7:0] ID_HOLDOFF = 8'h6a;
   localparam logic [7:0] ID_FORCE_RETRACT = 8'h6d;
   localparam logic [7:0] ID_FORCE_EXTEND = 8'h6e;
   localparam logic [7:0] ID_RETRACT_TARGET = 8'h6f;
   localparam logic [7:0] ID_EXTEND_TARGET = 8'h70;
   localparam logic [7:0] ID_RETRACT_FLAG = 8'h71;
   localparam logic [7:0] ID_EXTEND_FLAG = 8'h72;
   localparam logic [7:0] ID_RETRACT_THRESH = 8'h73;
   localparam logic [7:0] ID_EXTEND_THRESH = 8'h74;
   localparam logic [7:0] ID_FAULT_SUMMARY = 8'h75;

   // reset values
   localparam logic [15:0] RST_SETTLE_WINDOW = 16'h0032;
   localparam logic [7:0] RST_HOLDOFF = 8'h00;
   localparam logic [15:0] RST_RETRACT_TARGET = 16'h2710;
   localparam logic [15:0] RST_EXTEND_TARGET = 16'h0000;
   localparam logic [15:0] RST_RETRACT_THRESH = 16'h2648;
   localparam logic [15:0] RST_EXTEND_THRESH = 16'h00c8;

   // value ranges, 0.01 % units, signed except the window constants; WINDOW_TENTHS_MAX in 0.1 %
   localparam logic signed [15:0] POS_MIN = -16'sd50;
   localparam logic signed [15:0] POS_MAX = 16'sd10050;
   localparam logic signed [15:0] POS_FULL = 16'sd10000;
   localparam logic signed [15:0] POS_ZERO = 16'sd0;
   localparam logic [15:0] WINDOW_MIN = 16'd10;
   localparam logic [15:0] WINDOW_MAX = 16'd1000;
   localparam logic signed [15:0] TARGET_STEP = 16'sd10;
   localparam logic [15:0] WINDOW_STEP = 16'd10;
   localparam logic [15:0] WINDOW_TENTHS_MAX = 16'd99;

   // hold-off timing
   localparam int CLK_FREQ_HZ = 10000000;
   localparam int HOLDOFF_UNIT_MS = 100;
   localparam int HOLDOFF_UNIT_CYCLES = CLK_FREQ_HZ / 1000 * HOLDOFF_UNIT_MS;
   localparam int HOLDOFF_CNT_W = 20;

   // class version, value is arbitrary
   localparam logic [15:0] CLASS_VERSION = 16'h0003;

   typedef enum logic [1:0] {ST_READY, ST_MOVE, ST_HOLD} motion_t;
endpackage

/* File: hw/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic pin,
   output logic level
);
   logic meta;
   logic stage2;
   logic stage3;

   // meta is read only by stage2
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end else begin
         meta <= pin;
         stage2 <= meta;
         stage3 <= stage2;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         level <= 1'b0;
      end else if (stage2 == stage3) begin
         level <= stage3;
      end
   end
endmodule

/* File: test/stem_plant.sv */
// behavioural stem and motor plant on the far side of the motor outputs
`timescale 1ns/100ps
module stem_plant (
   input wire logic clk_sys,
   input wire logic motor_retract,
   input wire logic motor_extend,
   input wire logic jam,
   output logic [15:0] stem_position,
   output logic motor_stalled
);
   // coarse step keeps full travel near two thousand cycles
   initial stem_position = 16'h0000;
   // a jammed stem still draws current, so stall shows only while driven
   assign motor_stalled = jam & (motor_retract | motor_extend);
   always @(negedge clk_sys) begin
      if (!jam && motor_retract && $signed(stem_position) < 16'sd10050) begin
         stem_position <= stem_position + 16'h0005;
      end else if (!jam && motor_extend && $signed(stem_position) > -16'sd50) begin
         stem_position <= stem_position - 16'h0005;
      end
   end
endmodule

/* File: test/actuator_position_object_tb.sv */
// self-checking bench of the actuator positioning object
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
   $display("wrong value %s exp %h got %h", nm, ex, got); end end
module actuator_position_object_tb;
   logic clk_sys, rstn, local_switch, motor_stalled, clear_stall, memory_error, jam;
   logic [15:0] stem_position, attr_wdata, attr_rdata, stem_setpoint, rq;
   logic [7:0] retry_limit, attr_id;
   logic attr_class, attr_rd, attr_wr, attr_ack, attr_err, re, motor_retract, motor_extend;
   logic position_settled, retract_limit_flag, extend_limit_flag, fault_summary;
   int mismatches = 0, n_compared = 0, i, v;
   logic [31:0] seed = 32'h36c08cd8;
   logic [7:0] did [6] = '{8'h69, 8'h6a, 8'h6f, 8'h70, 8'h73, 8'h74};
   logic [15:0] dex [6] = '{16'h0032, 16'h0000, 16'h2710, 16'h0000, 16'h2648, 16'h00c8};
   logic [7:0] bid [6] = '{8'h50, 8'h6d, 8'h67, 8'h65, 8'h69, 8'h6a};
   logic bw [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
   logic [15:0] bd [6] = '{16'h0000, 16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0100};
   int corner [5] = '{-50, 10050, 1239, -45, 0};
   actuator_position_object #(.HOLDOFF_TICK_CYCLES(4)) i_dut (.clk_sys(clk_sys), .rstn(rstn),
      .local_switch(local_switch), .motor_stalled(motor_stalled), .clear_stall(clear_stall),
      .memory_error(memory_error), .stem_position(stem_position), .retry_limit(retry_limit),
      .attr_class(attr_class), .attr_id(attr_id), .attr_rd(attr_rd), .attr_wr(attr_wr),
      .attr_wdata(attr_wdata), .attr_ack(attr_ack), .attr_err(attr_err),
      .attr_rdata(attr_rdata), .motor_retract(motor_retract), .motor_extend(motor_extend),
      .stem_setpoint(stem_setpoint), .position_settled(position_settled),
      .retract_limit_flag(retract_limit_flag), .extend_limit_flag(extend_limit_flag),
      .fault_summary(fault_summary));
   stem_plant i_plant (.clk_sys(clk_sys), .motor_retract(motor_retract),
      .motor_extend(motor_extend), .jam(jam), .stem_position(stem_position),
      .motor_stalled(motor_stalled));
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // setpoint keeps whole 0.1 % steps, cut toward zero
   function logic [15:0] trunc10(input int t);
      return 16'(t / 10 * 10);
   endfunction
   task results();
      if (mismatches == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task acc(input logic cls, input logic wr, input logic [7:0] id, input logic [15:0] d);
      @(negedge clk_sys);
      attr_class = cls; attr_id = id; attr_wr = wr; attr_rd = !wr; attr_wdata = d;
      @(negedge clk_sys);
      `CHK("attr_ack", 1'b1, attr_ack)
      rq = attr_rdata;
      re = attr_err;
      attr_rd = 1'b0; attr_wr = 1'b0;
      @(negedge clk_sys);
      `CHK("attr_ack pulse", 1'b0, attr_ack)
   endtask
   task wr(input logic [7:0] id, input logic [15:0] d, input logic ee);
      acc(1'b0, 1'b1, id, d);
      `CHK("attr_err", ee, re)
   endtask
   task settle();
      int k;
      repeat (4) @(negedge clk_sys);
      for (k = 0; k < 4000 && !(position_settled === 1'b1 && motor_retract === 1'b0
         && motor_extend === 1'b0); k++) @(negedge clk_sys);
      `CHK("settled", 1'b1, position_settled)
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      #(100 * 60000);
      mismatches++;
      results();
   end
   initial begin
      rstn = 1'b0; local_switch = 1'b0; clear_stall = 1'b0; memory_error = 1'b0; jam = 1'b0;
      retry_limit = 8'h05; attr_class = 1'b0; attr_id = 8'h00; attr_rd = 1'b0;
      attr_wr = 1'b0; attr_wdata = 16'h0000;
      repeat (5) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (8) @(negedge clk_sys);
      for (i = 0; i < 6; i++) begin
         acc(1'b0, 1'b0, did[i], 16'h0000);
         `CHK("reset value", dex[i], rq)
      end
      acc(1'b1, 1'b0, 8'h01, 16'h0000);
      `CHK("class version", 16'h0003, rq)
      for (i = 0; i < 6; i++) begin
         acc(1'b0, bw[i], bid[i], bd[i]);
         `CHK("refused", 1'b1, re)
      end
      acc(1'b1, 1'b1, 8'h01, 16'h0000);
      `CHK("class write", 1'b1, re)
      wr(8'h65, 16'h0001, 1'b0);
      for (i = 0; i < 13; i++) begin
         seed = lfsr(seed);
         v = (i < 5) ? corner[i] : int'(seed % 32'd10101) - 50;
         wr(8'h66, 16'(v), 1'b0);
         `CHK("stem_setpoint", trunc10(v), stem_setpoint)
      end
      // an even 0.4 % window must act as 0.3 %, so 2 x error stays within 30
      wr(8'h69, 16'd40, 1'b0);
      wr(8'h66, 16'd5000, 1'b0);
      settle();
      v = int'($signed(stem_setpoint)) - int'($signed(stem_position));
      `CHK("inside window", 1'b1, (2 * (v < 0 ? -v : v) <= 30))
      acc(1'b0, 1'b0, 8'h67, 16'h0000);
      `CHK("position_feedback", stem_position, rq)
      wr(8'h6d, 16'h0001, 1'b0);
      `CHK("stem_setpoint", 16'd10000, stem_setpoint)
      settle();
      `CHK("flags", 2'b10, {retract_limit_flag, extend_limit_flag})
      wr(8'h6e, 16'h0001, 1'b0);
      wr(8'h6d, 16'h0000, 1'b0);
      `CHK("stem_setpoint", 16'd0, stem_setpoint)
      settle();
      `CHK("flags", 2'b01, {retract_limit_flag, extend_limit_flag})
      wr(8'h6e, 16'h0000, 1'b0);
      wr(8'h65, 16'h0000, 1'b0);
      wr(8'h66, 16'd3000, 1'b0);
      repeat (20) @(negedge clk_sys);
      `CHK("motor off", 2'b00, {motor_retract, motor_extend})
      wr(8'h66, 16'd10060, 1'b0);
      `CHK("fault_summary", 1'b1, fault_summary)
      wr(8'h66, 16'd100, 1'b0);
      `CHK("fault_summary", 1'b0, fault_summary)
      local_switch = 1'b1;
      repeat (8) @(negedge clk_sys);
      acc(1'b0, 1'b0, 8'h64, 16'h0000);
      `CHK("source switch", 16'h0001, rq)
      wr(8'h65, 16'h0001, 1'b1);
      local_switch = 1'b0;
      repeat (8) @(negedge clk_sys);
      retry_limit = 8'h01;
      jam = 1'b1;
      wr(8'h65, 16'h0001, 1'b0);
      wr(8'h66, 16'd5000, 1'b0);
      repeat (30) @(negedge clk_sys);
      `CHK("stall fault", 3'b100, {fault_summary, motor_retract, motor_extend})
      clear_stall = 1'b1;
      jam = 1'b0;
      repeat (10) @(negedge clk_sys);
      clear_stall = 1'b0;
      `CHK("stall cleared", 1'b0, fault_summary)
      settle();
      // three hold-off units of four cycles keep the motor off after the next stop
      wr(8'h6a, 16'h0003, 1'b0);
      wr(8'h66, 16'd5500, 1'b0);
      settle();
      wr(8'h66, 16'd5000, 1'b0);
      repeat (4) @(negedge clk_sys);
      `CHK("holdoff", 2'b00, {motor_retract, motor_extend})
      settle();
      memory_error = 1'b1;
      @(negedge clk_sys);
      memory_error = 1'b0;
      wr(8'h66, 16'd2000, 1'b0);
      repeat (20) @(negedge clk_sys);
      `CHK("storage fault", 3'b100, {fault_summary, motor_retract, motor_extend})
      results();
   end
endmodule
